// ===== hw/sbf_pkg.sv
/*
 Service bus access filter package: address map, slave selects, window limits,
 transfer sizes and the request/answer carriers.
 Assumes a 36-bit service bus address and 32-bit data.
*/
package sbf_pkg;
    // ----------------------------------------------------------------
    // widths and sizes
    // ----------------------------------------------------------------
    localparam int ADDR_W = 36;
    localparam int DATA_W = 32;
    localparam int SYNC_STAGES = 3;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int PAGE_SHIFT = 10;

    // ----------------------------------------------------------------
    // slave selects
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_UNALLOC = 4'h0;
    localparam logic [3:0] SEL_DEBUG   = 4'h1;
    localparam logic [3:0] SEL_HSB     = 4'h4;
    localparam logic [3:0] SEL_HSB_ALT = 4'h5;
    localparam logic [3:0] SEL_MSU     = 4'h6;

    // ----------------------------------------------------------------
    // windows
    // ----------------------------------------------------------------
    localparam logic [35:0] FLASH_BASE    = 36'h580000000;
    localparam logic [35:0] RAM_BASE      = 36'h500000000;
    localparam logic [35:0] UPAGE_START   = 36'h580800000;
    localparam logic [35:0] UPAGE_END     = 36'h581000000;
    localparam logic [35:0] DCOMM_START   = 36'h100000110;
    localparam logic [35:0] DCOMM_END     = 36'h100000118;
    localparam logic [35:0] FLCTL_START   = 36'h5FFFE0000;
    localparam logic [35:0] FLCTL_END     = 36'h5FFFE0400;
    localparam logic [35:0] FLASH_SIZE_DF = 36'h000040000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [35:0] addr;
        logic [1:0]  size;
        logic        write;
        logic [31:0] wdata;
    } sbf_req_t;

    typedef struct packed {
        logic        write;
        logic [31:0] rdata;
        logic        error;
    } sbf_rsp_t;

    typedef struct packed {
        logic        secure_mode;
        logic        security_bit;
        logic        user_code_protect_bit;
        logic [31:0] user_page_config_word;
        logic [35:0] boot_protect_size;
    } sbf_sec_t;

    typedef enum logic [1:0] {
        SBF_IDLE,
        SBF_WAKE,
        SBF_BUSY
    } sbf_state_t;
endpackage

// ===== hw/sbf_sync.sv
/*
 Three-stage synchroniser for a toggle or level from another clock domain.
 Assumes the input is held long enough for two agreeing late stages.
*/
`timescale 1ns/10ps
module sbf_sync (
    input  wire logic core_clk,
    input  wire logic rst_sync_b,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage;

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], async_in};
        end
    end

    // change counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sync_out <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            sync_out <= stage[2];
        end
    end
endmodule // sbf_sync

// ===== hw/sbf_filter.sv
/*
 Service bus access filter: takes debugger requests across a toggle handshake,
 checks size, alignment, slave select and security windows, forwards allowed
 accesses to one slave and answers the debugger with data or an error.
 Assumes the debugger holds request fields stable from its toggle until the
 answer toggle returns, and each slave answers with a one-cycle done pulse.
 The clock wake request follows the synchronised toggle, so the clock manager
 must restart a stopped core clock on debugger activity before the toggle is
 seen here.
*/
// Functional notes
// - 36-bit address; top four bits pick slave, low 32 go to slave
// - transfers are byte, halfword or word sized
// - select 1 goes to debug unit, 4 to memory space, 0 unallocated
// - select 5 aliases memory space, 6 reaches memory service unit
// - access completes only with clock; request raises clock wake, not sleep exit
// - debugger requests cross domains by handshake; no debugger rate limit
// - each security measure enabled by control signals, blocks or allows ranges
// - secure mode blocks flash and RAM secure areas sized by config word
// - secure mode makes user page read only; other accesses normal
// - security bit allows only debug comm registers and user page reads
// - plus code protect allows flash controller window and unprotected flash
`timescale 1ns/10ps
module sbf_filter (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              dbg_req_tgl,
    input  wire sbf_pkg::sbf_req_t dbg_req,
    output sbf_pkg::sbf_rsp_t      dbg_rsp,
    output logic                   dbg_ack_tgl,
    output logic                   clk_wake_req,
    input  wire sbf_pkg::sbf_sec_t sec,
    input  wire logic [35:0]       flash_size,
    output logic [3:0]             slv_sel,
    output sbf_pkg::sbf_req_t      slv_req,
    output logic                   slv_valid,
    input  wire logic              slv_done,
    input  wire logic [31:0]       slv_rdata
);
    import sbf_pkg::*;

    // ----------------------------------------------------------------
    // reset release and request crossing
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_sync_b;
    logic       req_tgl_s;
    logic       req_seen;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe[1];

    sbf_sync u_req_sync (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_b),
        .async_in   (dbg_req_tgl),
        .sync_out   (req_tgl_s)
    );

    // ----------------------------------------------------------------
    // request capture
    // ----------------------------------------------------------------
    sbf_state_t state;
    sbf_state_t next_state;
    sbf_req_t   req;
    logic       new_req;

    assign new_req = (req_tgl_s != req_seen) && (state == SBF_IDLE);

    // ----------------------------------------------------------------
    // decode and checks
    // ----------------------------------------------------------------
    wire [3:0]  sel      = req.addr[35:32];
    wire [35:0] a        = req.addr;
    wire        size_ok  = (req.size == SIZE_BYTE) || (req.size == SIZE_HALF)
                         || (req.size == SIZE_WORD);
    wire        align_ok = (req.size == SIZE_BYTE)
                         || ((req.size == SIZE_HALF) && !a[0])
                         || ((req.size == SIZE_WORD) && (a[1:0] == 2'h0));
    wire        sel_ok   = (sel == SEL_DEBUG) || (sel == SEL_HSB)
                         || (sel == SEL_HSB_ALT) || (sel == SEL_MSU);

    // ----------------------------------------------------------------
    // security windows
    // ----------------------------------------------------------------
    wire [35:0] sflash_end = FLASH_BASE
                           + (36'(sec.user_page_config_word[15:0]) << PAGE_SHIFT);
    wire [35:0] sram_end   = RAM_BASE
                           + (36'(sec.user_page_config_word[31:16]) << PAGE_SHIFT);
    wire in_sflash = (a >= FLASH_BASE) && (a < sflash_end);
    wire in_sram   = (a >= RAM_BASE) && (a < sram_end);
    wire in_upage  = (a >= UPAGE_START) && (a < UPAGE_END);
    wire in_dcomm  = (a >= DCOMM_START) && (a < DCOMM_END);
    wire in_flctl  = (a >= FLCTL_START) && (a < FLCTL_END);
    wire [35:0] flfree_lo = FLASH_BASE + sec.boot_protect_size;
    wire [35:0] flfree_hi = FLASH_BASE + flash_size;
    wire in_flfree = (a >= flfree_lo) && (a < flfree_hi);

    wire secure_ok = !(in_sflash || in_sram) && !(in_upage && req.write);
    wire lock_ok   = in_dcomm || (in_upage && !req.write);
    wire prot_ok   = lock_ok || in_flctl || in_flfree;

    logic allow;
    always_comb begin
        allow = 1'b1;
        if (sec.secure_mode && !secure_ok) begin
            allow = 1'b0;
        end
        if (sec.security_bit) begin
            allow = allow && (sec.user_code_protect_bit ? prot_ok : lock_ok);
        end
    end

    wire pass = size_ok && align_ok && sel_ok && allow;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SBF_IDLE: begin
                if (new_req) begin
                    next_state = SBF_WAKE;
                end
            end
            SBF_WAKE: begin
                if (pass) begin
                    next_state = SBF_BUSY;
                end else begin
                    next_state = SBF_IDLE;
                end
            end
            SBF_BUSY: begin
                if (slv_done) begin
                    next_state = SBF_IDLE;
                end
            end
            default: begin
                next_state = SBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= SBF_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            req      <= '0;
            req_seen <= 1'b0;
        end else if (new_req) begin
            req      <= dbg_req;
            req_seen <= req_tgl_s;
        end
    end

    // ----------------------------------------------------------------
    // slave side and answer
    // ----------------------------------------------------------------
    wire start_slv = (state == SBF_WAKE) && pass;
    wire refuse    = (state == SBF_WAKE) && !pass;
    wire slv_end   = (state == SBF_BUSY) && slv_done;
    wire answer    = refuse || slv_end;
    wire wake_next = (next_state != SBF_IDLE);

    sbf_rsp_t next_rsp;
    sbf_req_t next_slv_req;

    assign next_rsp     = {req.write,
                           (refuse ? 32'h0 : slv_rdata),
                           refuse};
    assign next_slv_req = {4'h0, req.addr[31:0],
                           req.size, req.write, req.wdata};

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            clk_wake_req <= 1'b0;
        end else begin
            clk_wake_req <= wake_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            slv_valid <= 1'b0;
        end else begin
            slv_valid <= start_slv;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            slv_sel <= SEL_UNALLOC;
            slv_req <= '0;
        end else if (start_slv) begin
            slv_sel <= sel;
            slv_req <= next_slv_req;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dbg_rsp     <= '0;
            dbg_ack_tgl <= 1'b0;
        end else if (answer) begin
            dbg_rsp     <= next_rsp;
            dbg_ack_tgl <= ~dbg_ack_tgl;
        end
    end
endmodule // sbf_filter

// ===== tb/sbf_filter_sva.sv
/* Filter port checker; assumes the package window constants. */
`timescale 1ns/10ps
module sbf_filter_sva (
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire sbf_pkg::sbf_rsp_t dbg_rsp,
    input wire logic              dbg_ack_tgl,
    input wire logic              clk_wake_req,
    input wire sbf_pkg::sbf_sec_t sec,
    input wire logic [3:0]        slv_sel,
    input wire sbf_pkg::sbf_req_t slv_req,
    input wire logic              slv_valid,
    input wire logic              slv_done
);
    import sbf_pkg::*;
    wire logic [35:0] fa = {slv_sel, slv_req.addr[31:0]};
    wire logic up = fa >= UPAGE_START && fa < UPAGE_END;
    wire logic dc = fa >= DCOMM_START && fa < DCOMM_END;
    wire logic sa = (fa >= FLASH_BASE && fa < FLASH_BASE + {sec.user_page_config_word[15:0], 10'h0})
        || (fa >= RAM_BASE && fa < RAM_BASE + {sec.user_page_config_word[31:16], 10'h0});
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_done; slv_done && clk_wake_req; endsequence
    sequence s_refuse; $changed(dbg_ack_tgl) && dbg_rsp.error; endsequence
    sel_map_a: assert property (slv_valid |-> slv_sel inside {4'h1, 4'h4, 4'h5, 4'h6})
        else $error("bad select");
    addr_low_a: assert property (slv_valid |-> slv_req.addr[35:32] == 4'h0)
        else $error("high bits passed");
    size_align_a: assert property (slv_valid |-> slv_req.size != 2'h3
        && (slv_req.size == 2'h0 || !slv_req.addr[0]) && (slv_req.size != 2'h2 || !slv_req.addr[1]))
        else $error("bad size or alignment");
    wake_pulse_a: assert property ($rose(slv_valid) |-> clk_wake_req ##1 !slv_valid)
        else $error("bad start pulse");
    answer_done_a: assert property (s_done |=> $changed(dbg_ack_tgl) && !dbg_rsp.error)
        else $error("no answer");
    refuse_quiet_a: assert property (s_refuse |-> dbg_rsp.rdata == 32'h0 && !$past(slv_valid))
        else $error("refusal not quiet");
    secure_area_a: assert property (slv_valid && sec.secure_mode |-> !sa && !(up && slv_req.write))
        else $error("secure area reached");
    secbit_only_a: assert property (slv_valid && sec.security_bit && !sec.user_code_protect_bit
        |-> dc || (up && !slv_req.write)) else $error("locked access passed");
endmodule // sbf_filter_sva

bind sbf_filter sbf_filter_sva u_sva (.core_clk, .rst_b, .dbg_rsp, .dbg_ack_tgl,
    .clk_wake_req, .sec, .slv_sel, .slv_req, .slv_valid, .slv_done);

// ===== tb/sbf_slave_model.sv
/* Slave model answering after lat cycles; assumes one-cycle valid pulses. */
`timescale 1ns/10ps
module sbf_slave_model (
    input  wire logic              core_clk,
    input  wire logic              slv_valid,
    input  wire sbf_pkg::sbf_req_t slv_req,
    input  wire logic [3:0]        lat,
    output logic                   slv_done,
    output logic [31:0]            slv_rdata
);
    import sbf_pkg::*;
    initial begin
        slv_done = 1'b0;
        slv_rdata = 32'h0;
        forever begin
            @(posedge core_clk iff slv_valid);
            repeat (lat) @(posedge core_clk);
            #1 slv_done = 1'b1;
            slv_rdata = slv_req.addr[31:0] ^ 32'hA5A5A5A5;
            @(posedge core_clk) #1 slv_done = 1'b0;
            slv_rdata = ~slv_rdata;
        end
    end
endmodule // sbf_slave_model

// ===== tb/tb.sv
/* Filter bench; assumes the slave model and the bound checker. */
`timescale 1ns/10ps
module tb;
    import sbf_pkg::*;
    logic        core_clk = 1'b0, rst_b = 1'b0, tgl = 1'b0, ack, wake, sv, sd;
    logic [3:0]  sel, lat = 4'h0;
    logic [31:0] srd;
    sbf_req_t    req = '0, sreq;
    sbf_rsp_t    rsp;
    sbf_sec_t    sec = '0;
    logic [35:0] fsz = FLASH_SIZE_DF;
    int          n_fail = 0, comparisons = 0;
    sbf_filter dut (.core_clk, .rst_b, .dbg_req_tgl(tgl), .dbg_req(req), .dbg_rsp(rsp),
        .dbg_ack_tgl(ack), .clk_wake_req(wake), .sec, .flash_size(fsz), .slv_sel(sel),
        .slv_req(sreq), .slv_valid(sv), .slv_done(sd), .slv_rdata(srd));
    sbf_slave_model slv (.core_clk, .slv_valid(sv), .slv_req(sreq), .lat, .slv_done(sd),
        .slv_rdata(srd));
    initial forever #50 core_clk = ~core_clk;
    task chk_ans(input logic [4:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task chk_slv(input logic [75:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task chk_data(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task summarize;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task a(input logic [35:0] ad, input logic wr, er, input logic [1:0] sz = 2'h2);
        logic     o;
        logic     w;
        sbf_req_t x;
        o = ack;
        w = 1'b0;
        x = '{{4'h0, ad[31:0]}, sz, wr, ~ad[31:0]};
        req = '{ad, sz, wr, ~ad[31:0]};
        tgl = ~tgl;
        for (int i = 0; i < 60 && ack === o; i++) begin
            @(posedge core_clk) #1;
            w = w | wake;
        end
        chk_ans({ack, rsp.error, rsp.write, wake, w}, {~o, er, wr, 1'b0, 1'b1});
        if (!er) chk_slv({sv, sel, sreq}, {1'b0, ad[35:32], x});
        if (er || !wr) chk_data(rsp.rdata, er ? 32'h0 : ad[31:0] ^ 32'hA5A5A5A5);
        @(posedge core_clk) #1;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge core_clk) #1;
        chk_ans({ack, rsp.error, rsp.write, wake, sv}, 5'h00);
        chk_slv({sv, sel, sreq}, 76'h0);
        chk_data(rsp.rdata, 32'h0);
        for (int s = 0; s < 16; s++) a({s[3:0], 32'h100}, 0, !(s inside {1, 4, 5, 6}));
        lat = 4'h3;
        a(36'h400000001, 0, 0, 2'h0);
        a(36'h400000002, 1, 0, 2'h1);
        a(36'h400000001, 0, 1, 2'h1);
        a(36'h400000004, 0, 1, 2'h3);
        sec = '{1'b1, 1'b0, 1'b0, 32'h00020001, 36'h0};
        a(36'h5800003FC, 0, 1);
        a(36'h580000400, 1, 0);
        a(36'h5000007FC, 1, 1);
        a(36'h580800000, 0, 0);
        a(36'h580800000, 1, 1);
        sec = '{1'b0, 1'b1, 1'b0, 32'h0, 36'h0};
        a(36'h100000110, 1, 0);
        a(36'h100000118, 0, 1);
        a(36'h580800004, 0, 0);
        a(36'h580800004, 1, 1);
        a(36'h5FFFE0000, 1, 1);
        sec = '{1'b0, 1'b1, 1'b1, 32'h0, 36'h2000};
        a(36'h5FFFE0000, 1, 0);
        a(36'h5FFFE0400, 1, 1);
        a(36'h580001FFC, 1, 1);
        a(36'h580002000, 1, 0);
        a(36'h580040000, 0, 1);
        fsz = 36'h000020000;
        a(36'h58001FFFC, 1, 0);
        a(36'h580020000, 1, 1);
        summarize;
    end
    initial begin
        #1000000 n_fail++;
        summarize;
    end
endmodule // tb
